// file: wuc_pkg.sv
// shared constants and carrier types of the unified write-back cache
package wuc_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int CACHE_BYTES = 8192;
  localparam int LINE_BYTES = 16;
  localparam int NUM_WAYS = 4;
  localparam int WORD_BYTES = 4;
  localparam int WORDS_PER_LINE = LINE_BYTES / WORD_BYTES;
  localparam int NUM_SETS = CACHE_BYTES / (LINE_BYTES * NUM_WAYS);
  localparam int BYTE_W = 2;
  localparam int WORD_W = 2;
  localparam int SET_W = 7;
  localparam int WAY_W = 2;
  localparam int SET_LSB = BYTE_W + WORD_W;
  localparam int TAG_LSB = SET_LSB + SET_W;
  localparam int TAG_W = ADDR_W - TAG_LSB;
  localparam int LIDX_W = WAY_W + SET_W;
  localparam int DIDX_W = LIDX_W + WORD_W;
  localparam int WBUF_DEPTH = 8;
  localparam int BUS_DIV = 2;
  localparam logic [WAY_W-1:0] AGE_OLDEST = 2'h3;
  localparam logic [WORD_W-1:0] LAST_WORD = 2'h3;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } wuc_wr_t;
  typedef struct packed {
    logic req;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } wuc_core_req_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EVICT = 2'b01,
    ST_FILL = 2'b11
  } wuc_state_t;
  typedef enum logic {
    BS_IDLE = 1'b0,
    BS_WAIT = 1'b1
  } wuc_bus_state_t;
endpackage

// file: wuc_wbuf.sv
// posted-write buffer between the cache and the external bus
`timescale 1ns/1ps
`default_nettype none
module wuc_wbuf #(
  parameter int DEPTH = 8
) (
  input wire logic core_clk_i, // core clock
  input wire logic reset_i, // synchronous reset, active high
  input wire logic in_valid_i, // push request
  output logic in_ready_o, // room for one more entry
  input wire wuc_pkg::wuc_wr_t in_data_i, // pushed write
  output logic out_valid_o, // buffer not empty
  input wire logic out_ready_i, // pop
  output wuc_pkg::wuc_wr_t out_data_o // oldest write
);
  import wuc_pkg::*;
  localparam int PTR_W = $clog2(DEPTH);
  wuc_wr_t mem [DEPTH]; // entries, no reset needed
  logic [PTR_W-1:0] wr_reg, wr_next; // write pointer
  logic [PTR_W-1:0] rd_reg, rd_next; // read pointer
  logic [PTR_W:0] cnt_reg, cnt_next; // fill level
  logic push, pop;

  // refuse depths that the wrapping pointers cannot serve
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("write buffer depth must be a power of two");
  end

  // honest full and empty come straight from the level
  always_comb
  begin
    in_ready_o = (cnt_reg != DEPTH[PTR_W:0]);
    out_valid_o = (cnt_reg != '0);
    out_data_o = mem[rd_reg];
    push = in_valid_i && in_ready_o;
    pop = out_ready_i && out_valid_o;
    wr_next = push ? wr_reg + 1'b1 : wr_reg;
    rd_next = pop ? rd_reg + 1'b1 : rd_reg;
    cnt_next = cnt_reg;
    if (push && !pop)
      cnt_next = cnt_reg + 1'b1;
    else if (pop && !push)
      cnt_next = cnt_reg - 1'b1;
  end

  // pointer registers and entry storage
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
    if (push)
      mem[wr_reg] <= in_data_i;
  end
endmodule
`default_nettype wire

// file: wuc_cache.sv
// four-way unified cache with write-back dirty words and posted writes
`timescale 1ns/1ps
`default_nettype none
module wuc_cache (
  input wire logic core_clk_i, // core clock, 50 MHz
  input wire logic reset_i, // synchronous reset, active high
  input wire logic wb_mode_i, // 1 write-back, 0 write-through
  input wire wuc_pkg::wuc_core_req_t core_i, // core request, held until ack
  output logic core_ack_o, // one-cycle answer
  output logic [wuc_pkg::DATA_W-1:0] core_rdata_o, // read data, valid with ack
  output logic bus_req_o, // external cycle request
  output logic bus_we_o, // external cycle is a write
  output logic [wuc_pkg::ADDR_W-1:0] bus_addr_o, // external word address
  output logic [wuc_pkg::DATA_W-1:0] bus_wdata_o, // external write data
  input wire logic bus_ack_i, // external cycle done, from pins
  input wire logic [wuc_pkg::DATA_W-1:0] bus_rdata_i, // external read data
  input wire logic snoop_i, // other master wants a line
  input wire logic [wuc_pkg::ADDR_W-1:0] snoop_addr_i // snooped address
);
  import wuc_pkg::*;
  localparam int LINES = NUM_WAYS * NUM_SETS;

  // storage arrays
  logic [DATA_W-1:0] data_mem [LINES*WORDS_PER_LINE];
  logic [TAG_W-1:0] tag_mem [LINES]; // line tags
  logic [LINES-1:0] valid_mem; // one valid per line
  logic [WORDS_PER_LINE-1:0] dirty_mem [LINES]; // one dirty per word
  logic [WAY_W-1:0] age_mem [LINES]; // 0 newest, 3 oldest

  // control state
  wuc_state_t state_reg, state_next;
  logic [WAY_W-1:0] way_reg, way_next; // line being evicted or filled
  logic [SET_W-1:0] set_reg, set_next;
  logic [TAG_W-1:0] tag_reg, tag_next; // victim tag for write-back address
  logic [WORD_W-1:0] cnt_reg, cnt_next; // word walker
  logic snp_reg, snp_next; // eviction is for a snoop
  logic ack_reg, ack_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;

  // bus side state
  wuc_bus_state_t bst_reg, bst_next;
  logic breq_reg, breq_next, bwe_reg, bwe_next;
  logic [ADDR_W-1:0] baddr_reg, baddr_next;
  logic [DATA_W-1:0] bwdata_reg, bwdata_next;
  logic div_reg, div_next; // bus enable divider

  // pin synchronisers, first stages read only by second stages
  logic ack_s1, ack_s2, ack_s3, snp_s1, snp_s2, snp_s3;
  logic [DATA_W-1:0] rd_s1, rd_s2;
  logic [ADDR_W-1:0] sa_s1, sa_s2;
  logic spend_reg, spend_next; // pending snoop, set wins over take
  logic [ADDR_W-1:0] saddr_reg, saddr_next;

  // write buffer link
  logic wb_push, wb_in_ready, wb_out_valid, wb_pop;
  wuc_wr_t wb_in, wb_out;

  // lookup and update strobes
  logic [ADDR_W-1:0] look_addr;
  logic [SET_W-1:0] look_set;
  logic [TAG_W-1:0] look_tag;
  logic [NUM_WAYS-1:0] hit_vec;
  logic hit;
  logic [WAY_W-1:0] hit_way, victim;
  logic dwr_en, dirty_wr, touch, tag_wr, inval;
  logic [DIDX_W-1:0] dwr_idx;
  logic [DATA_W-1:0] dwr_data;
  logic [WORDS_PER_LINE-1:0] dirty_val;
  logic [LIDX_W-1:0] cur_line;
  logic rd_done, bus_en, ack_pulse, snp_pulse;

  wuc_wbuf #(.DEPTH(WBUF_DEPTH)) u_wbuf (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .in_valid_i(wb_push),
    .in_ready_o(wb_in_ready),
    .in_data_i(wb_in),
    .out_valid_o(wb_out_valid),
    .out_ready_i(wb_pop),
    .out_data_o(wb_out)
  );

  // one tag comparator per way; a pending snoop takes the port in ST_IDLE, ahead of a core request
  assign look_addr = (state_reg == ST_IDLE && spend_reg) ? saddr_reg : core_i.addr;
  assign look_set = look_addr[TAG_LSB-1:SET_LSB];
  assign look_tag = look_addr[ADDR_W-1:TAG_LSB];
  genvar gw;
  generate
    for (gw = 0; gw < NUM_WAYS; gw++)
    begin : g_way
      assign hit_vec[gw] = valid_mem[{WAY_W'(gw), look_set}]
                           && tag_mem[{WAY_W'(gw), look_set}] == look_tag;
    end
  endgenerate

  // hit way and victim; an empty way is used before the oldest one
  always_comb
  begin
    hit = |hit_vec;
    hit_way = '0;
    victim = '0;
    for (int w = NUM_WAYS - 1; w >= 0; w--)
    begin
      if (hit_vec[w])
        hit_way = w[WAY_W-1:0];
      if (age_mem[{w[WAY_W-1:0], look_set}] == AGE_OLDEST)
        victim = w[WAY_W-1:0];
    end
    for (int w = NUM_WAYS - 1; w >= 0; w--)
      if (!valid_mem[{w[WAY_W-1:0], look_set}])
        victim = w[WAY_W-1:0];
  end

  // cache controller: lookup, eviction walk, line fill
  always_comb
  begin
    state_next = state_reg;
    way_next = way_reg;
    set_next = set_reg;
    tag_next = tag_reg;
    cnt_next = cnt_reg;
    snp_next = snp_reg;
    ack_next = 1'b0;
    rdata_next = rdata_reg;
    spend_next = spend_reg;
    saddr_next = saddr_reg;
    wb_push = 1'b0;
    wb_in = '{addr: core_i.addr, data: core_i.wdata};
    dwr_en = 1'b0;
    dwr_idx = {hit_way, look_set, look_addr[SET_LSB-1:BYTE_W]};
    dwr_data = core_i.wdata;
    dirty_wr = 1'b0;
    dirty_val = '0;
    touch = 1'b0;
    tag_wr = 1'b0;
    inval = 1'b0;
    cur_line = {hit_way, look_set};
    case (state_reg)
      ST_IDLE:
      begin
        if (spend_reg)
        begin
          // another master needs the line: flush dirty words, then drop it
          spend_next = 1'b0;
          if (hit && dirty_mem[cur_line] != '0)
          begin
            way_next = hit_way;
            set_next = look_set;
            tag_next = look_tag;
            cnt_next = '0;
            snp_next = 1'b1;
            state_next = ST_EVICT;
          end
          else if (hit)
            inval = 1'b1;
        end
        else if (core_i.req && !ack_reg)
        begin
          if (hit)
          begin
            if (!core_i.we)
            begin
              rdata_next = data_mem[dwr_idx];
              ack_next = 1'b1;
              touch = 1'b1;
            end
            else if (wb_mode_i)
            begin
              dwr_en = 1'b1;
              dirty_wr = 1'b1;
              dirty_val = dirty_mem[cur_line];
              dirty_val[look_addr[SET_LSB-1:BYTE_W]] = 1'b1;
              ack_next = 1'b1;
              touch = 1'b1;
            end
            else if (wb_in_ready)
            begin
              dwr_en = 1'b1;
              wb_push = 1'b1;
              ack_next = 1'b1;
              touch = 1'b1;
            end
          end
          else if (core_i.we)
          begin
            // no allocation on a write miss; a full buffer stalls the core
            if (wb_in_ready)
            begin
              wb_push = 1'b1;
              ack_next = 1'b1;
            end
          end
          else
          begin
            way_next = victim;
            set_next = look_set;
            tag_next = tag_mem[{victim, look_set}];
            cnt_next = '0;
            snp_next = 1'b0;
            if (valid_mem[{victim, look_set}] && dirty_mem[{victim, look_set}] != '0)
              state_next = ST_EVICT;
            else
              state_next = ST_FILL;
          end
        end
      end
      ST_EVICT:
      begin
        // walk the four words, only dirty ones leave the chip
        cur_line = {way_reg, set_reg};
        wb_in = '{addr: {tag_reg, set_reg, cnt_reg, 2'b00},
                  data: data_mem[{way_reg, set_reg, cnt_reg}]};
        if (!dirty_mem[cur_line][cnt_reg] || wb_in_ready)
        begin
          wb_push = dirty_mem[cur_line][cnt_reg];
          cnt_next = cnt_reg + 1'b1;
          if (cnt_reg == LAST_WORD)
          begin
            inval = 1'b1;
            cnt_next = '0;
            snp_next = 1'b0;
            state_next = snp_reg ? ST_IDLE : ST_FILL;
          end
        end
      end
      ST_FILL:
      begin
        cur_line = {way_reg, set_reg};
        dwr_idx = {way_reg, set_reg, cnt_reg};
        dwr_data = rd_s2;
        if (rd_done)
        begin
          dwr_en = 1'b1;
          cnt_next = cnt_reg + 1'b1;
          if (cnt_reg == LAST_WORD)
          begin
            tag_wr = 1'b1;
            state_next = ST_IDLE;
          end
        end
      end
      default:
        state_next = ST_IDLE;
    endcase
    if (snp_pulse)
    begin
      spend_next = 1'b1; // a new snoop wins over the take
      saddr_next = sa_s2;
    end
  end

  // bus side: one cycle issued per enable pulse at half the core rate
  always_comb
  begin
    div_next = (BUS_DIV == 2) ? !div_reg : 1'b1;
    bus_en = div_reg;
    ack_pulse = ack_s2 && !ack_s3;
    snp_pulse = snp_s2 && !snp_s3;
    bst_next = bst_reg;
    breq_next = breq_reg;
    bwe_next = bwe_reg;
    baddr_next = baddr_reg;
    bwdata_next = bwdata_reg;
    wb_pop = 1'b0;
    rd_done = 1'b0;
    case (bst_reg)
      BS_IDLE:
      begin
        if (bus_en)
        begin
          // posted writes drain first so a fill never overtakes them
          if (wb_out_valid)
          begin
            wb_pop = 1'b1;
            breq_next = 1'b1;
            bwe_next = 1'b1;
            baddr_next = wb_out.addr;
            bwdata_next = wb_out.data;
            bst_next = BS_WAIT;
          end
          else if (state_reg == ST_FILL)
          begin
            breq_next = 1'b1;
            bwe_next = 1'b0;
            baddr_next = {core_i.addr[ADDR_W-1:SET_LSB], cnt_reg, 2'b00};
            bst_next = BS_WAIT;
          end
        end
      end
      BS_WAIT:
      begin
        if (ack_pulse)
        begin
          breq_next = 1'b0;
          rd_done = !bwe_reg;
          bst_next = BS_IDLE;
        end
      end
      default:
        bst_next = BS_IDLE;
    endcase
  end

  // control registers and pin synchronisers
  always_ff @(posedge core_clk_i)
  begin
    ack_s1 <= bus_ack_i;
    ack_s2 <= ack_s1;
    ack_s3 <= ack_s2;
    snp_s1 <= snoop_i;
    snp_s2 <= snp_s1;
    snp_s3 <= snp_s2;
    rd_s1 <= bus_rdata_i;
    rd_s2 <= rd_s1;
    sa_s1 <= snoop_addr_i;
    sa_s2 <= sa_s1;
    if (reset_i)
    begin
      state_reg <= ST_IDLE;
      way_reg <= '0;
      set_reg <= '0;
      tag_reg <= '0;
      cnt_reg <= '0;
      snp_reg <= 1'b0;
      ack_reg <= 1'b0;
      rdata_reg <= '0;
      spend_reg <= 1'b0;
      saddr_reg <= '0;
      bst_reg <= BS_IDLE;
      breq_reg <= 1'b0;
      bwe_reg <= 1'b0;
      baddr_reg <= '0;
      bwdata_reg <= '0;
      div_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      way_reg <= way_next;
      set_reg <= set_next;
      tag_reg <= tag_next;
      cnt_reg <= cnt_next;
      snp_reg <= snp_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
      spend_reg <= spend_next;
      saddr_reg <= saddr_next;
      bst_reg <= bst_next;
      breq_reg <= breq_next;
      bwe_reg <= bwe_next;
      baddr_reg <= baddr_next;
      bwdata_reg <= bwdata_next;
      div_reg <= div_next;
    end
  end

  // array updates; only valid and ages need a reset value
  always_ff @(posedge core_clk_i)
  begin
    if (dwr_en)
      data_mem[dwr_idx] <= dwr_data;
    if (dirty_wr)
      dirty_mem[cur_line] <= dirty_val;
    if (tag_wr)
    begin
      tag_mem[cur_line] <= core_i.addr[ADDR_W-1:TAG_LSB];
      dirty_mem[cur_line] <= '0;
    end
    if (reset_i)
    begin
      valid_mem <= '0;
      for (int l = 0; l < LINES; l++)
        age_mem[l] <= l[LIDX_W-1:SET_W]; // distinct ages per set
    end
    else
    begin
      if (inval)
        valid_mem[cur_line] <= 1'b0;
      if (tag_wr)
        valid_mem[cur_line] <= 1'b1;
      if (touch)
        for (int w = 0; w < NUM_WAYS; w++)
          if (age_mem[{w[WAY_W-1:0], look_set}] < age_mem[cur_line])
            age_mem[{w[WAY_W-1:0], look_set}] <= age_mem[{w[WAY_W-1:0], look_set}] + 1'b1;
      if (touch)
        age_mem[cur_line] <= '0;
    end
  end

  assign core_ack_o = ack_reg;
  assign core_rdata_o = rdata_reg;
  assign bus_req_o = breq_reg;
  assign bus_we_o = bwe_reg;
  assign bus_addr_o = baddr_reg;
  assign bus_wdata_o = bwdata_reg;
endmodule
`default_nettype wire

// file: wuc_mem_model.sv
// behavioural external memory that answers the cache's bus cycles
`timescale 1ns/1ps
`default_nettype none
module wuc_mem_model (
  input wire logic core_clk_i, // core clock
  input wire logic slow_i, // add wait states
  input wire logic bus_req_i, // cycle request
  input wire logic bus_we_i, // cycle is a write
  input wire logic [wuc_pkg::ADDR_W-1:0] bus_addr_i, // word address
  input wire logic [wuc_pkg::DATA_W-1:0] bus_wdata_i, // write data
  output logic bus_ack_o, // cycle done
  output logic [wuc_pkg::DATA_W-1:0] bus_rdata_o // read data
);
  logic [31:0] mem [logic [31:0]]; // words written so far
  // one cycle at a time; data is set up long before ack, as the sync needs
  initial
  begin
    bus_ack_o = 1'b0;
    bus_rdata_o = 32'h0000_0000;
    forever
    begin
      @(posedge core_clk_i);
      if (bus_req_i && !bus_ack_o)
      begin
        bus_rdata_o <= mem.exists(bus_addr_i) ? mem[bus_addr_i] : bus_addr_i ^ 32'h3c3c_c3c3;
        if (bus_we_i)
          mem[bus_addr_i] = bus_wdata_i;
        repeat (slow_i ? 12 : 4) @(posedge core_clk_i);
        bus_ack_o <= 1'b1;
        while (bus_req_i) @(posedge core_clk_i);
        bus_ack_o <= 1'b0;
        bus_rdata_o <= ~bus_rdata_o; // released lines show no stale data
      end
    end
  end
endmodule
`default_nettype wire

// file: wuc_cache_sva.sv
// port assertions of the unified cache
`timescale 1ns/1ps
`default_nettype none
module wuc_cache_sva (
  input wire logic core_clk_i, // core clock
  input wire logic reset_i, // sync reset
  input wire logic wb_mode_i, // cache mode
  input wire wuc_pkg::wuc_core_req_t core_i, // core request
  input wire logic core_ack_o, // core answer
  input wire logic [wuc_pkg::DATA_W-1:0] core_rdata_o, // read data
  input wire logic bus_req_o, // bus cycle
  input wire logic bus_we_o, // bus write
  input wire logic [wuc_pkg::ADDR_W-1:0] bus_addr_o, // bus address
  input wire logic [wuc_pkg::DATA_W-1:0] bus_wdata_o, // bus write data
  input wire logic bus_ack_i, // bus done
  input wire logic [wuc_pkg::DATA_W-1:0] bus_rdata_i, // bus read data
  input wire logic snoop_i, // snoop request
  input wire logic [wuc_pkg::ADDR_W-1:0] snoop_addr_i // snooped address
);
  import wuc_pkg::*;
  logic req_d_reg, req_d_next; // bus request a cycle ago
  logic fill_reg, fill_next; // a line fill is part way
  logic [ADDR_W-1:0] faddr_reg, faddr_next; // next fill word expected
  logic issue; // a new bus cycle starts
  logic par_reg, par_next; // mirrors the every-other-cycle bus slot from reset
  assign issue = bus_req_o && !req_d_reg;
  // track fill progress from the read cycles seen
  always_comb
  begin
    req_d_next = bus_req_o;
    par_next = !par_reg;
    fill_next = fill_reg;
    faddr_next = faddr_reg;
    if (issue && !bus_we_o)
    begin
      fill_next = bus_addr_o[3:2] != LAST_WORD;
      faddr_next = bus_addr_o + 32'h0000_0004;
    end
  end
  always_ff @(posedge core_clk_i)
  begin
    req_d_reg <= reset_i ? 1'b0 : req_d_next;
    par_reg <= reset_i ? 1'b0 : par_next;
    fill_reg <= reset_i ? 1'b0 : fill_next;
    faddr_reg <= faddr_next;
  end
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);
  sequence s_held;
    bus_req_o ##1 bus_req_o;
  endsequence
  sequence s_fill_read;
    issue && !bus_we_o;
  endsequence
  chk_ack_pulse: assert property (core_ack_o |=> !core_ack_o)
    else $error("core ack longer than one cycle");
  chk_ack_cause: assert property (core_ack_o |-> $past(core_i.req))
    else $error("core ack without request");
  chk_rdata_hold: assert property ($changed(core_rdata_o) |-> core_ack_o && !$past(core_i.we))
    else $error("read data moved outside a read answer");
  chk_addr_align: assert property (bus_req_o |-> bus_addr_o[1:0] == 2'h0)
    else $error("bus address not word aligned");
  chk_bus_steady: assert property (s_held |-> $stable({bus_we_o, bus_addr_o, bus_wdata_o}))
    else $error("bus cycle changed while pending");
  chk_req_wait: assert property (bus_req_o && !bus_ack_i |=> bus_req_o)
    else $error("bus request dropped before ack");
  chk_req_drop: assert property ($rose(bus_ack_i) |-> s_held ##[1:3] !bus_req_o)
    else $error("bus request not ended after ack");
  chk_fill_next: assert property (issue && fill_reg |-> !bus_we_o && bus_addr_o == faddr_reg)
    else $error("fill words out of order");
  chk_fill_first: assert property ((s_fill_read and !fill_reg) |-> bus_addr_o[3:2] == 2'h0)
    else $error("fill does not start at word zero");
  chk_bus_half: assert property (issue |-> !par_reg)
    else $error("bus cycle started outside the half-rate slot");
endmodule
bind wuc_cache wuc_cache_sva wuc_cache_sva_i (.core_clk_i(core_clk_i), .reset_i(reset_i),
  .wb_mode_i(wb_mode_i), .core_i(core_i), .core_ack_o(core_ack_o), .core_rdata_o(core_rdata_o),
  .bus_req_o(bus_req_o), .bus_we_o(bus_we_o), .bus_addr_o(bus_addr_o),
  .bus_wdata_o(bus_wdata_o), .bus_ack_i(bus_ack_i), .bus_rdata_i(bus_rdata_i),
  .snoop_i(snoop_i), .snoop_addr_i(snoop_addr_i));
`default_nettype wire

// file: test_writeback_unified_cache.sv
// self-checking bench of the unified cache against a memory model
`timescale 1ns/1ps
`default_nettype none
module test_writeback_unified_cache;
  import wuc_pkg::*;
  logic clk, rst, wb, snp, slow; // clock, reset, mode, snoop, slow memory
  wuc_core_req_t core; // core request
  logic ack, breq, bwe, back, bprev; // handshakes
  logic [31:0] rdat, baddr, bwdat, brdat, saddr, a; // data and addresses
  logic [31:0] shadow [logic [31:0]]; // coherent memory image
  logic [31:0] wlog [$]; // addresses of bus writes
  int n_tests, err_total, nrd, nwr, lat, mx; // counters
  wuc_cache wuc_cache_i (.core_clk_i(clk), .reset_i(rst), .wb_mode_i(wb), .core_i(core),
    .core_ack_o(ack), .core_rdata_o(rdat), .bus_req_o(breq), .bus_we_o(bwe),
    .bus_addr_o(baddr), .bus_wdata_o(bwdat), .bus_ack_i(back), .bus_rdata_i(brdat),
    .snoop_i(snp), .snoop_addr_i(saddr));
  wuc_mem_model wuc_mem_model_i (.core_clk_i(clk), .slow_i(slow), .bus_req_i(breq),
    .bus_we_i(bwe), .bus_addr_i(baddr), .bus_wdata_i(bwdat), .bus_ack_o(back),
    .bus_rdata_o(brdat));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // count bus cycles at the falling edge, clear of the driving edge
  always @(negedge clk)
  begin
    bprev <= breq;
    if (breq && !bprev)
    begin
      if (bwe)
        wlog.push_back(baddr);
      if (bwe)
        nwr++;
      else
        nrd++;
    end
  end
  // expected memory word: written value, else the model's fill pattern
  function automatic logic [31:0] exp_rd(input logic [31:0] x);
    return shadow.exists(x) ? shadow[x] : x ^ 32'h3c3c_c3c3;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one core access, request held until ack; reads are checked
  task automatic op(input logic we, input logic [31:0] x, input logic [31:0] d);
    int k;
    k = 0;
    core <= '{1'b1, we, x, d};
    do
    begin
      @(posedge clk);
      k++;
    end
    while (ack !== 1'b1 && k < 600);
    if (ack !== 1'b1)
      check(ack, 32'h0000_0001);
    lat = k;
    core.req <= 1'b0;
    if (we)
      shadow[x] = d;
    else
      check(rdat, exp_rd(x));
    @(posedge clk); // lets the request fall before a new one
  endtask
  task automatic wait_wr(input int n);
    int k;
    k = 0;
    while (nwr < n && k < 600)
    begin
      @(posedge clk);
      k++;
    end
    if (nwr < n)
      check(nwr, n);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog: far beyond the longest expected run
  initial
  begin
    #(20 * 60000);
    err_total++;
    conclude();
  end
  initial
  begin
    rst = 1'b1;
    wb = 1'b1;
    snp = 1'b0;
    slow = 1'b0;
    saddr = 32'h0000_0000;
    bprev = 1'b0;
    core = '0;
    n_tests = 0;
    err_total = 0;
    nrd = 0;
    nwr = 0;
    void'($urandom(32'haa2c));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // read miss fills four words, the next word of the line hits at once
    op(0, 32'h0000_1004, 0);
    check(nrd, 4);
    op(0, 32'h0000_1008, 0);
    check(lat, 2);
    check(nrd, 4);
    $display("test fill_hit done");
    // write-through hit goes out to memory as well
    wb <= 1'b0;
    nwr = 0;
    wlog = {};
    op(1, 32'h0000_1008, 32'h1234_5678);
    wait_wr(1);
    check(nwr, 1);
    check(wlog[0], 32'h0000_1008);
    op(0, 32'h0000_1008, 0);
    $display("test write_through done");
    // write-back hit stays inside; victims follow recency, dirty word only
    wb <= 1'b1;
    for (int t = 0; t < 4; t++) op(0, 32'h0000_0050 + t * 32'h0000_0800, 0);
    nwr = 0;
    wlog = {};
    op(1, 32'h0000_0058, 32'hdead_0001);
    for (int t = 4; t < 7; t++) op(0, 32'h0000_0050 + t * 32'h0000_0800, 0);
    check(nwr, 0);
    op(0, 32'h0000_3850, 0);
    check(nwr, 1);
    check(wlog[0], 32'h0000_0058);
    op(0, 32'h0000_0058, 0);
    $display("test lru_evict done");
    // write miss is sent out and leaves no line behind
    nwr = 0;
    nrd = 0;
    wlog = {};
    op(1, 32'h0000_7300, 32'h0bad_cafe);
    wait_wr(1);
    check(wlog[0], 32'h0000_7300);
    op(0, 32'h0000_7300, 0);
    check(nrd, 4);
    $display("test write_miss done");
    // eight posted writes do not stall the core behind slow memory
    wb <= 1'b0;
    slow <= 1'b1;
    nwr = 0;
    mx = 0;
    for (int i = 0; i < 8; i++)
    begin
      op(1, 32'h0001_0000 + i * 4, $urandom());
      mx = lat > mx ? lat : mx;
    end
    check(mx, 2);
    wait_wr(8);
    check(nwr, 8);
    slow <= 1'b0;
    $display("test write_buffers done");
    // snoop flushes the dirty word and drops the line
    wb <= 1'b1;
    op(0, 32'h0000_2000, 0);
    op(1, 32'h0000_2004, 32'h5555_aaaa);
    nwr = 0;
    nrd = 0;
    wlog = {};
    saddr <= 32'h0000_2000;
    repeat (3) @(posedge clk);
    snp <= 1'b1;
    repeat (3) @(posedge clk);
    snp <= 1'b0;
    wait_wr(1);
    check(wlog[0], 32'h0000_2004);
    op(0, 32'h0000_2004, 0);
    check(nrd, 4);
    $display("test snoop done");
    // random traffic over six lines of one set in both modes
    for (int i = 0; i < 300; i++)
    begin
      wb <= 1'($urandom_range(1, 0));
      a = 32'h0000_0030 + ($urandom_range(5, 0) << 11) + ($urandom_range(3, 0) << 2);
      op(1'($urandom_range(1, 0)), a, $urandom());
    end
    $display("test random done");
    conclude();
  end
endmodule
`default_nettype wire
